// ### cdc_pkg.sv
`default_nettype none
package cdc_pkg;
   // Register byte addresses on the APB bus
   localparam logic [7:0] ADDR_DAC_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_DAC_LEVEL = 8'h04;
   localparam logic [7:0] ADDR_CMP1_CTRL_A = 8'h08;
   localparam logic [7:0] ADDR_CMP1_CTRL_B = 8'h0c;
   localparam logic [7:0] ADDR_CMP2_CTRL_A = 8'h10;
   localparam logic [7:0] ADDR_CMP2_CTRL_B = 8'h14;
   localparam logic [7:0] ADDR_CMP_MIRROR = 8'h18;
   localparam logic [7:0] ADDR_CMP_STATUS = 8'h1c;

   // Converter control field positions
   localparam int DAC_EN_BIT = 7;
   localparam int DAC_LPS_BIT = 6;
   localparam int DAC_OE_BIT = 5;
   localparam int DAC_PSS_LSB = 2;
   localparam int DAC_NSS_BIT = 0;
   localparam logic [7:0] DAC_CONTROL_MASK = 8'hed;
   localparam logic [7:0] DAC_LEVEL_MASK = 8'h1f;
   localparam logic [7:0] DAC_CONTROL_RESET = 8'h00;
   localparam logic [4:0] DAC_LEVEL_RESET = 5'h00;
   localparam logic [4:0] DAC_LEVEL_ALL_ONES = 5'h1f;
   localparam logic [4:0] DAC_LEVEL_ALL_ZEROS = 5'h00;

   // Comparator control A field positions
   localparam int CMP_ON_BIT = 7;
   localparam int CMP_RESULT_BIT = 6;
   localparam int CMP_OE_BIT = 5;
   localparam int CMP_INV_BIT = 4;
   localparam int CMP_SP_BIT = 2;
   localparam int CMP_HYS_BIT = 1;
   localparam int CMP_SYNC_BIT = 0;
   localparam logic [7:0] CMP_CTRL_A_MASK = 8'hb7;
   localparam logic [7:0] CMP_CTRL_A_RESET = 8'h04;
   // Comparator control B field positions
   localparam int CMP_RISE_BIT = 7;
   localparam int CMP_FALL_BIT = 6;
   localparam logic [7:0] CMP_CTRL_B_MASK = 8'hf3;
   localparam logic [7:0] CMP_CTRL_B_RESET = 8'h00;

   typedef enum logic [1:0] {
      PSS_SUPPLY = 2'h0,
      PSS_EXT_REF = 2'h1,
      PSS_FIXED_REF = 2'h2,
      PSS_RESERVED = 2'h3
   } cdc_pos_src_t;

   typedef enum logic [2:0] {
      DAC_OFF = 3'h1,
      DAC_CLAMP_POS = 3'h2,
      DAC_CLAMP_NEG = 3'h4
   } cdc_dac_mode_t;

   typedef struct packed {
      logic enable;
      logic lowPower;
      logic pinOutEnable;
      cdc_pos_src_t posSrc;
      logic negSrc;
      logic [4:0] levelCode;
   } cdc_dac_cfg_t;

   typedef struct packed {
      logic on;
      logic pinDriveEnable;
      logic invert;
      logic speedSel;
      logic hystEnable;
      logic timerSync;
      logic riseIrqEn;
      logic fallIrqEn;
      logic [1:0] posChan;
      logic [1:0] negChan;
   } cdc_cmp_cfg_t;
endpackage
`default_nettype wire

// ### cdc_cmp_channel.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_cmp_channel (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire cdc_pkg::cdc_cmp_cfg_t cfg,
   input wire logic rawAsync,
   input wire logic timerClkAsync,
   input wire logic flagClear,
   output logic result,
   output logic syncResult,
   output logic pinDrive,
   output logic edgeEvent
);
   logic rawMeta_q, rawSync_q, tclkMeta_q, tclkSync_q, tclkPrev_q;
   logic latched_q, sync_q, prevResult_q, flag_q;
   wire logic polResult;
   wire logic tclkFall;
   wire logic riseEvt;
   wire logic fallEvt;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rawMeta_q <= 1'b0;
         rawSync_q <= 1'b0;
         tclkMeta_q <= 1'b0;
         tclkSync_q <= 1'b0;
         tclkPrev_q <= 1'b0;
      end else begin
         rawMeta_q <= rawAsync;
         rawSync_q <= rawMeta_q;
         tclkMeta_q <= timerClkAsync;
         tclkSync_q <= tclkMeta_q;
         tclkPrev_q <= tclkSync_q;
      end
   end

   // Off comparator has its inputs disconnected and reads low before polarity
   assign polResult = (cfg.on & rawSync_q) ^ cfg.invert;
   assign tclkFall = tclkPrev_q & ~tclkSync_q;

   // ----------------------------------------
   // Result latches and edge flag
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         latched_q <= 1'b0;
         sync_q <= 1'b0;
         prevResult_q <= 1'b0;
      end else begin
         latched_q <= polResult;
         prevResult_q <= latched_q;
         if (tclkFall) begin
            sync_q <= latched_q;
         end
      end
   end

   assign riseEvt = cfg.riseIrqEn & latched_q & ~prevResult_q;
   assign fallEvt = cfg.fallIrqEn & ~latched_q & prevResult_q;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else begin
         // A new edge wins over a clear in the same cycle
         flag_q <= (riseEvt | fallEvt) | (flag_q & ~flagClear);
      end
   end

   assign result = latched_q;
   // Timer gate sees the synchronised copy only when asked for it
   assign syncResult = cfg.timerSync ? sync_q : latched_q;
   // Pin path is not latched: it follows the polarity output directly
   assign pinDrive = polResult;
   assign edgeEvent = flag_q;
endmodule
`default_nettype wire

// ### cdc_dac_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_dac_ctrl (
   input wire cdc_pkg::cdc_dac_cfg_t cfg,
   output cdc_pkg::cdc_dac_mode_t mode,
   output logic ladderPosConnect,
   output logic ladderNegConnect,
   output logic refPinConnect
);
   wire logic clampPos;
   wire logic clampNeg;

   assign clampPos = ~cfg.enable & cfg.lowPower & (cfg.posSrc != cdc_pkg::PSS_RESERVED)
                     & (cfg.levelCode == cdc_pkg::DAC_LEVEL_ALL_ONES);
   assign clampNeg = ~cfg.enable & ~cfg.lowPower
                     & (cfg.levelCode == cdc_pkg::DAC_LEVEL_ALL_ZEROS);
   assign mode = clampPos ? cdc_pkg::DAC_CLAMP_POS :
                 (clampNeg ? cdc_pkg::DAC_CLAMP_NEG : cdc_pkg::DAC_OFF);
   // Clamp modes connect only one end of the ladder; enable connects both
   assign ladderPosConnect = cfg.enable | clampPos;
   assign ladderNegConnect = cfg.enable | clampNeg;
   assign refPinConnect = cfg.pinOutEnable;
endmodule
`default_nettype wire

// ### cdc_comparator_dac_control.sv
// How it works
// - Reset disables converter, removes pin voltage, clears five-bit level code.
// - Disabled, low-power set, valid positive source, code all ones clamps positive.
// - Disabled, low-power clear, code all zeros clamps to negative source.
// - Pin output enable routes level to pin, overriding digital buffer and detector.
// - Digital reads of the reference pin return zero while in converter output.
// - Waking from sleep leaves converter control register untouched.
// - Level register holds code in bits 4..0; bits 7..5 read zero.
// - Comparator on bit enables it; clear disables for least current.
// - Result readable in control register and in the shared mirror register.
// - Pin driven only with drive enable set, direction clear, comparator on.
// - Drive enable overrides port data latch; on bit does not affect override.
// - Internal result latched every cycle; external pin path is not latched.
// - Raw result high when non-inverting input above inverting input.
// - Invert bit inverts result; clear passes it unchanged.
// - Speed select resets to one for normal speed; zero selects low power.
// - Hysteresis bit enables hysteresis; its amount follows speed select.
// - Each comparator result selectable as gate source for the timer.
// - Sync bit latches result on falling edge of timer source clock.
// - With prescaler in use, the latch clock is taken after it.
// - Timer counts on rising edge, opposite the falling latch edge.
// - Flag set on rising edge with rise enable, falling edge with fall enable.
// - Software clears flag; an edge in the clearing cycle keeps it set.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module cdc_comparator_dac_control #(
   parameter int NUM_CMP = 2
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleepWake,
   input wire logic [NUM_CMP-1:0] cmpRawAsync,
   input wire logic timerClkAsync,
   input wire logic [NUM_CMP-1:0] cmpPinDirection,
   input wire logic [NUM_CMP-1:0] cmpPortLatch,
   input wire logic refPinDigitalIn,
   output logic [NUM_CMP-1:0] cmpPinOut,
   output logic [NUM_CMP-1:0] cmpPinOe,
   output logic [NUM_CMP-1:0] cmpPinOverride,
   output logic [NUM_CMP-1:0] cmpTimerGate,
   output logic [NUM_CMP-1:0] cmpIrqFlag,
   output logic [NUM_CMP-1:0] cmpSpeedSel,
   output logic [NUM_CMP-1:0] cmpHystEnable,
   output logic [NUM_CMP-1:0] cmpEnable,
   output logic [4:0] dacLevelCode,
   output logic dacEnable,
   output logic [1:0] dacPosSourceSel,
   output logic dacNegSourceSel,
   output logic dacLadderPos,
   output logic dacLadderNeg,
   output cdc_pkg::cdc_dac_mode_t dacMode,
   output logic refOutPinConnect,
   output logic refOutPinDigitalBufOff,
   output logic refPinDigitalRead
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (NUM_CMP != 2) begin : g_bad_num
      $error("cdc_comparator_dac_control supports exactly two comparators");
   end

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [7:0] dacControl_q;
   logic [4:0] dacLevel_q;
   logic [7:0] cmpCtrlA_q [NUM_CMP];
   logic [7:0] cmpCtrlB_q [NUM_CMP];
   logic refInMeta_q, refInSync_q;
   logic [31:0] prdata_q;
   logic [NUM_CMP-1:0] cmpResult;
   logic [NUM_CMP-1:0] cmpSyncResult;
   logic [NUM_CMP-1:0] cmpPolResult;
   logic [NUM_CMP-1:0] cmpFlag;
   logic [NUM_CMP-1:0] flagClear;
   cdc_pkg::cdc_cmp_cfg_t cmpCfg [NUM_CMP];
   cdc_pkg::cdc_dac_cfg_t dacCfg;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   wire logic accessPhase;
   wire logic wrEn;
   wire logic rdEn;
   wire logic selDacCtl;
   wire logic selDacLvl;
   wire logic [NUM_CMP-1:0] selCmpA;
   wire logic [NUM_CMP-1:0] selCmpB;
   wire logic selMirror;
   wire logic selStatus;
   wire logic mapped;

   assign accessPhase = psel & penable;
   assign wrEn = accessPhase & pwrite;
   assign rdEn = accessPhase & ~pwrite;
   assign selDacCtl = hit(paddr, cdc_pkg::ADDR_DAC_CONTROL);
   assign selDacLvl = hit(paddr, cdc_pkg::ADDR_DAC_LEVEL);
   assign selCmpA[0] = hit(paddr, cdc_pkg::ADDR_CMP1_CTRL_A);
   assign selCmpB[0] = hit(paddr, cdc_pkg::ADDR_CMP1_CTRL_B);
   assign selCmpA[1] = hit(paddr, cdc_pkg::ADDR_CMP2_CTRL_A);
   assign selCmpB[1] = hit(paddr, cdc_pkg::ADDR_CMP2_CTRL_B);
   assign selMirror = hit(paddr, cdc_pkg::ADDR_CMP_MIRROR);
   assign selStatus = hit(paddr, cdc_pkg::ADDR_CMP_STATUS);
   assign mapped = selDacCtl | selDacLvl | (|selCmpA) | (|selCmpB) | selMirror | selStatus;

   // Zero-wait slave: answer in the first access cycle
   assign pready = 1'b1;
   assign pslverr = accessPhase & ~mapped;
   assign prdata = prdata_q;

   // ----------------------------------------
   // Converter registers
   // ----------------------------------------
   // The wake input is deliberately not a term here: no sleep event touches them
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dacControl_q <= cdc_pkg::DAC_CONTROL_RESET;
         dacLevel_q <= cdc_pkg::DAC_LEVEL_RESET;
      end else begin
         if (wrEn && selDacCtl) begin
            dacControl_q <= pwdata[7:0] & cdc_pkg::DAC_CONTROL_MASK;
         end
         if (wrEn && selDacLvl) begin
            dacLevel_q <= pwdata[4:0];
         end
      end
   end
   wire logic sleepWakeUnused;
   assign sleepWakeUnused = sleepWake;

   assign dacCfg.enable = dacControl_q[cdc_pkg::DAC_EN_BIT];
   assign dacCfg.lowPower = dacControl_q[cdc_pkg::DAC_LPS_BIT];
   assign dacCfg.pinOutEnable = dacControl_q[cdc_pkg::DAC_OE_BIT];
   assign dacCfg.posSrc = cdc_pkg::cdc_pos_src_t'(dacControl_q[cdc_pkg::DAC_PSS_LSB +: 2]);
   assign dacCfg.negSrc = dacControl_q[cdc_pkg::DAC_NSS_BIT];
   assign dacCfg.levelCode = dacLevel_q;

   cdc_dac_ctrl u_dac (
      .cfg(dacCfg),
      .mode(dacMode),
      .ladderPosConnect(dacLadderPos),
      .ladderNegConnect(dacLadderNeg),
      .refPinConnect(refOutPinConnect)
   );

   assign dacEnable = dacCfg.enable;
   assign dacLevelCode = dacLevel_q;
   assign dacPosSourceSel = dacCfg.posSrc;
   assign dacNegSourceSel = dacCfg.negSrc;
   assign refOutPinDigitalBufOff = dacCfg.pinOutEnable;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         refInMeta_q <= 1'b0;
         refInSync_q <= 1'b0;
      end else begin
         refInMeta_q <= refPinDigitalIn;
         refInSync_q <= refInMeta_q;
      end
   end
   assign refPinDigitalRead = refInSync_q & ~dacCfg.pinOutEnable;

   // ----------------------------------------
   // Comparator channels
   // ----------------------------------------
   for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
      always_ff @(posedge ref_clk or negedge rst_b) begin
         if (!rst_b) begin
            cmpCtrlA_q[i] <= cdc_pkg::CMP_CTRL_A_RESET;
            cmpCtrlB_q[i] <= cdc_pkg::CMP_CTRL_B_RESET;
         end else begin
            if (wrEn && selCmpA[i]) begin
               cmpCtrlA_q[i] <= pwdata[7:0] & cdc_pkg::CMP_CTRL_A_MASK;
            end
            if (wrEn && selCmpB[i]) begin
               cmpCtrlB_q[i] <= pwdata[7:0] & cdc_pkg::CMP_CTRL_B_MASK;
            end
         end
      end

      assign cmpCfg[i].on = cmpCtrlA_q[i][cdc_pkg::CMP_ON_BIT];
      assign cmpCfg[i].pinDriveEnable = cmpCtrlA_q[i][cdc_pkg::CMP_OE_BIT];
      assign cmpCfg[i].invert = cmpCtrlA_q[i][cdc_pkg::CMP_INV_BIT];
      assign cmpCfg[i].speedSel = cmpCtrlA_q[i][cdc_pkg::CMP_SP_BIT];
      assign cmpCfg[i].hystEnable = cmpCtrlA_q[i][cdc_pkg::CMP_HYS_BIT];
      assign cmpCfg[i].timerSync = cmpCtrlA_q[i][cdc_pkg::CMP_SYNC_BIT];
      assign cmpCfg[i].riseIrqEn = cmpCtrlB_q[i][cdc_pkg::CMP_RISE_BIT];
      assign cmpCfg[i].fallIrqEn = cmpCtrlB_q[i][cdc_pkg::CMP_FALL_BIT];
      assign cmpCfg[i].posChan = cmpCtrlB_q[i][5:4];
      assign cmpCfg[i].negChan = cmpCtrlB_q[i][1:0];

      // Writing a one to the status bit clears that flag
      assign flagClear[i] = wrEn & selStatus & pwdata[i];

      cdc_cmp_channel u_chan (
         .ref_clk(ref_clk),
         .rst_b(rst_b),
         .cfg(cmpCfg[i]),
         .rawAsync(cmpRawAsync[i]),
         .timerClkAsync(timerClkAsync),
         .flagClear(flagClear[i]),
         .result(cmpResult[i]),
         .syncResult(cmpSyncResult[i]),
         .pinDrive(cmpPolResult[i]),
         .edgeEvent(cmpFlag[i])
      );

      // Override of the port latch follows drive enable alone
      assign cmpPinOverride[i] = cmpCfg[i].pinDriveEnable;
      assign cmpPinOut[i] = cmpCfg[i].pinDriveEnable ? cmpPolResult[i] : cmpPortLatch[i];
      assign cmpPinOe[i] = cmpCfg[i].pinDriveEnable & ~cmpPinDirection[i] & cmpCfg[i].on;
      assign cmpTimerGate[i] = cmpSyncResult[i];
      assign cmpSpeedSel[i] = cmpCfg[i].speedSel;
      // Analog side scales the hysteresis band by speed select
      assign cmpHystEnable[i] = cmpCfg[i].hystEnable;
      assign cmpEnable[i] = cmpCfg[i].on;
   end

   assign cmpIrqFlag = cmpFlag;

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire logic [7:0] cmpAView0;
   wire logic [7:0] cmpAView1;
   wire logic [31:0] readWord;

   assign cmpAView0 = {cmpCtrlA_q[0][7], cmpResult[0], cmpCtrlA_q[0][5:0]};
   assign cmpAView1 = {cmpCtrlA_q[1][7], cmpResult[1], cmpCtrlA_q[1][5:0]};
   assign readWord = selDacCtl ? {24'h000000, dacControl_q} :
                     selDacLvl ? {27'h0, dacLevel_q} :
                     selCmpA[0] ? {24'h000000, cmpAView0} :
                     selCmpB[0] ? {24'h000000, cmpCtrlB_q[0]} :
                     selCmpA[1] ? {24'h000000, cmpAView1} :
                     selCmpB[1] ? {24'h000000, cmpCtrlB_q[1]} :
                     selMirror ? {30'h0, cmpResult} :
                     selStatus ? {30'h0, cmpFlag} :
                     32'h00000000;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= readWord;
      end else if (rdEn) begin
         prdata_q <= readWord;
      end
   end
endmodule
`default_nettype wire

// ### cdc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_checker #(
   parameter int NUM_CMP = 2
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [NUM_CMP-1:0] cmpPinDirection,
   input wire logic [NUM_CMP-1:0] cmpPortLatch,
   input wire logic [NUM_CMP-1:0] cmpPinOut,
   input wire logic [NUM_CMP-1:0] cmpPinOe,
   input wire logic [NUM_CMP-1:0] cmpPinOverride,
   input wire logic [NUM_CMP-1:0] cmpIrqFlag,
   input wire logic [NUM_CMP-1:0] cmpSpeedSel,
   input wire logic [NUM_CMP-1:0] cmpEnable,
   input wire logic [4:0] dacLevelCode,
   input wire logic dacEnable,
   input wire cdc_pkg::cdc_dac_mode_t dacMode,
   input wire logic refOutPinConnect,
   input wire logic refPinDigitalRead
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire access = psel && penable;
   // ------
   // Port and converter relations
   // ------
   a_pin_drive_gate: assert property (cmpPinOe == (cmpPinOverride & ~cmpPinDirection & cmpEnable))
      else $error("pin drive enable wrong");
   a_latch_pass: assert property (((cmpPinOut ^ cmpPortLatch) & ~cmpPinOverride) == '0)
      else $error("port latch not passed");
   a_ref_read_zero: assert property (refOutPinConnect |-> !refPinDigitalRead)
      else $error("reference pin read not zero");
   a_clamp_pos: assert property (dacMode == cdc_pkg::DAC_CLAMP_POS |-> !dacEnable && dacLevelCode == 5'h1f)
      else $error("positive clamp without its conditions");
   a_clamp_neg: assert property (dacMode == cdc_pkg::DAC_CLAMP_NEG |-> !dacEnable && dacLevelCode == 5'h00)
      else $error("negative clamp without its conditions");
   a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> !dacEnable && !refOutPinConnect && dacLevelCode == 5'h00)
      else $error("converter not cleared by reset");
   a_speed_reset: assert property (disable iff (1'b0) !rst_b |=> cmpSpeedSel == '1)
      else $error("speed select not one after reset");
   // A flag may only drop through a status write in the cycle before
   a_irq_sticky: assert property (($past(cmpIrqFlag) & ~cmpIrqFlag) != '0 |-> $past(access && pwrite) && $past(paddr) == cdc_pkg::ADDR_CMP_STATUS)
      else $error("flag dropped without clear");
   a_level_upper_zero: assert property (access && !pwrite && paddr == cdc_pkg::ADDR_DAC_LEVEL |-> prdata[31:5] == 27'h0)
      else $error("level register upper bits not zero");
   a_slverr_map: assert property (access |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00))
      else $error("error response wrong");
endmodule
bind cdc_comparator_dac_control cdc_checker #(.NUM_CMP(NUM_CMP)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .cmpPinDirection(cmpPinDirection), .cmpPortLatch(cmpPortLatch), .cmpPinOut(cmpPinOut),
   .cmpPinOe(cmpPinOe), .cmpPinOverride(cmpPinOverride), .cmpIrqFlag(cmpIrqFlag),
   .cmpSpeedSel(cmpSpeedSel), .cmpEnable(cmpEnable), .dacLevelCode(dacLevelCode), .dacEnable(dacEnable),
   .dacMode(dacMode), .refOutPinConnect(refOutPinConnect), .refPinDigitalRead(refPinDigitalRead));
`default_nettype wire

// ### cdc_far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_far_side_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic tmrRun,
   input wire logic timerGate,
   output logic timerClk,
   output logic [15:0] timerCount
);
   int div;
   // Clock is already past the prescaler; parks high when stopped so no falling edge leaks out
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         timerClk <= 1'b1;
         div <= 0;
      end else if (tmrRun) begin
         div <= (div == 4) ? 0 : div + 1;
         if (div == 4) begin
            timerClk <= ~timerClk;
         end
      end else begin
         timerClk <= 1'b1;
      end
   end
   always @(posedge timerClk or negedge rst_b) begin
      if (!rst_b) begin
         timerCount <= 16'h0;
      end else if (timerGate) begin
         timerCount <= timerCount + 16'h1;
      end
   end
endmodule
`default_nettype wire

// ### cdc_comparator_dac_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cdc_comparator_dac_control_tb;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr, sleepWake = 1'b0, timerClk, tmrRun = 1'b0, refPinDigitalIn = 1'b0;
   logic [1:0] cmpRawAsync = 2'h0, cmpPinDirection = 2'h0, cmpPortLatch = 2'h0;
   logic [1:0] cmpPinOut, cmpPinOe, cmpPinOverride, cmpTimerGate, cmpIrqFlag, cmpSpeedSel, cmpHystEnable, cmpEnable;
   logic [1:0] dacPosSourceSel;
   logic [4:0] dacLevelCode;
   logic dacEnable, dacNegSourceSel, dacLadderPos, dacLadderNeg, refOutPinConnect, refOutPinDigitalBufOff;
   logic refPinDigitalRead;
   cdc_pkg::cdc_dac_mode_t dacMode;
   int bad_count = 0;
   int compares = 0;
   cdc_comparator_dac_control dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sleepWake, .cmpRawAsync, .timerClkAsync(timerClk), .cmpPinDirection, .cmpPortLatch,
      .refPinDigitalIn, .cmpPinOut, .cmpPinOe, .cmpPinOverride, .cmpTimerGate, .cmpIrqFlag, .cmpSpeedSel,
      .cmpHystEnable, .cmpEnable, .dacLevelCode, .dacEnable, .dacPosSourceSel, .dacNegSourceSel, .dacLadderPos,
      .dacLadderNeg, .dacMode, .refOutPinConnect, .refOutPinDigitalBufOff, .refPinDigitalRead);
   cdc_far_side_model far (.ref_clk, .rst_b, .tmrRun, .timerGate(cmpTimerGate[1]), .timerClk, .timerCount());
   always #12.5 ref_clk = ~ref_clk;
   // ------
   // Bus and check helpers
   // ------
   task automatic report_and_stop();
      if (bad_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, x, g);
      end
   endtask
   // Idle edge first, so a release and a new setup never share a time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Only the watchdog ends a stalled access
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, x, rdata);
   endtask
   task automatic waitn(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      report_and_stop();
   end
   // ------
   // Scenarios
   // ------
   initial begin
      logic [7:0] msk [6] = '{cdc_pkg::DAC_CONTROL_MASK, cdc_pkg::DAC_LEVEL_MASK, cdc_pkg::CMP_CTRL_A_MASK,
         cdc_pkg::CMP_CTRL_B_MASK, cdc_pkg::CMP_CTRL_A_MASK, cdc_pkg::CMP_CTRL_B_MASK};
      logic [7:0] rstv [8] = '{8'h00, 8'h00, cdc_pkg::CMP_CTRL_A_RESET, 8'h00, cdc_pkg::CMP_CTRL_A_RESET, 8'h00,
         8'h00, 8'h00};
      logic [31:0] d;
      logic e;
      int ch;
      d = $urandom(32'hff66ec68);
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rc(8'(4 * i), {24'h0, rstv[i]}, "reset value");
      end
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 6; i++) begin
            d = (r == 0) ? 32'hffffffff : $urandom();
            wr(8'(4 * i), d);
            apb(1'b0, 8'(4 * i), 32'h0);
            // Result bit of each comparator control is read-only and checked below
            chk("register readback", {24'h0, d[7:0] & msk[i]}, rdata & ((i == 2 || i == 4) ? ~32'h40 : ~32'h0));
         end
      end
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped read", 32'h0, rdata);
      chk("unmapped error", 32'h1, {31'h0, err});
      for (int k = 0; k < 16; k++) begin
         ch = k / 8;
         cmpPinDirection <= 2'($urandom());
         cmpPortLatch <= 2'($urandom());
         cmpRawAsync[ch] <= k[2];
         wr(ch ? cdc_pkg::ADDR_CMP2_CTRL_A : cdc_pkg::ADDR_CMP1_CTRL_A, {24'h0, k[0], 2'b01, k[1], 2'b01, k[3], 1'b0});
         waitn(6);
         e = (k[0] & k[2]) ^ k[1];
         chk("timer gate", e, cmpTimerGate[ch]);
         chk("pin out", e, cmpPinOut[ch]);
         chk("comparator on", k[0], cmpEnable[ch]);
         chk("hysteresis", k[3], cmpHystEnable[ch]);
         apb(1'b0, ch ? cdc_pkg::ADDR_CMP2_CTRL_A : cdc_pkg::ADDR_CMP1_CTRL_A, 32'h0);
         chk("result bit", e, rdata[6]);
         apb(1'b0, cdc_pkg::ADDR_CMP_MIRROR, 32'h0);
         chk("mirror bit", e, rdata[ch]);
      end
      cmpRawAsync[0] <= 1'b0;
      wr(cdc_pkg::ADDR_CMP1_CTRL_A, 32'h84);
      for (int m = 0; m < 2; m++) begin
         wr(cdc_pkg::ADDR_CMP1_CTRL_B, m ? 32'h40 : 32'h80);
         for (int s = 1; s >= 0; s--) begin
            wr(cdc_pkg::ADDR_CMP_STATUS, 32'h3);
            cmpRawAsync[0] <= s[0];
            waitn(6);
            chk("irq flag", m != s, cmpIrqFlag[0]);
         end
      end
      wr(cdc_pkg::ADDR_CMP_STATUS, 32'h1);
      waitn(1);
      chk("flag cleared", 1'b0, cmpIrqFlag[0]);
      // Falling edge reaches the flag at the very edge that applies the clear
      wr(cdc_pkg::ADDR_CMP1_CTRL_B, 32'hc0);
      cmpRawAsync[0] <= 1'b1;
      waitn(6);
      @(posedge ref_clk);
      cmpRawAsync[0] <= 1'b0;
      @(posedge ref_clk);
      wr(cdc_pkg::ADDR_CMP_STATUS, 32'h1);
      waitn(1);
      chk("set over clear", 1'b1, cmpIrqFlag[0]);
      wr(cdc_pkg::ADDR_CMP2_CTRL_A, 32'h85);
      waitn(8);
      chk("gate held", 1'b0, cmpTimerGate[1]);
      @(posedge ref_clk);
      tmrRun <= 1'b1;
      waitn(30);
      chk("gate synced", 1'b1, cmpTimerGate[1]);
      wr(cdc_pkg::ADDR_DAC_LEVEL, 32'h1f);
      wr(cdc_pkg::ADDR_DAC_CONTROL, 32'h40);
      waitn(0);
      chk("clamp positive", {cdc_pkg::DAC_CLAMP_POS, 2'b10}, {dacMode, dacLadderPos, dacLadderNeg});
      wr(cdc_pkg::ADDR_DAC_CONTROL, 32'h4c);
      waitn(0);
      chk("reserved source clamp", 1'b0, dacMode === cdc_pkg::DAC_CLAMP_POS);
      wr(cdc_pkg::ADDR_DAC_LEVEL, 32'h0);
      wr(cdc_pkg::ADDR_DAC_CONTROL, 32'h0);
      waitn(0);
      chk("clamp negative", {cdc_pkg::DAC_CLAMP_NEG, 2'b01}, {dacMode, dacLadderPos, dacLadderNeg});
      wr(cdc_pkg::ADDR_DAC_CONTROL, 32'ha5);
      refPinDigitalIn <= 1'b1;
      waitn(4);
      chk("dac outputs", 7'h5e, {dacEnable, dacPosSourceSel, dacNegSourceSel, refOutPinConnect,
         refOutPinDigitalBufOff, refPinDigitalRead});
      @(posedge ref_clk);
      sleepWake <= 1'b1;
      @(posedge ref_clk);
      sleepWake <= 1'b0;
      rc(cdc_pkg::ADDR_DAC_CONTROL, 32'ha5, "control after wake");
      wr(cdc_pkg::ADDR_DAC_CONTROL, 32'h0);
      waitn(4);
      chk("pin read released", 1'b1, refPinDigitalRead);
      wr(cdc_pkg::ADDR_DAC_CONTROL, 32'ha5);
      wr(cdc_pkg::ADDR_DAC_LEVEL, 32'h15);
      rst_b <= 1'b0;
      waitn(2);
      @(posedge ref_clk);
      rst_b <= 1'b1;
      rc(cdc_pkg::ADDR_DAC_CONTROL, 32'h0, "control after reset");
      rc(cdc_pkg::ADDR_DAC_LEVEL, 32'h0, "level after reset");
      report_and_stop();
   end
endmodule
`default_nettype wire
